// >>> logic/dds_core.sv
// dual channel dds core with apb registers, sync clock and mode checker
//
// How it works
// RQ1: two channels, 32-bit accumulators add tuning word
// RQ2: phase converted to amplitude by cosine
// RQ3: zero tuning word holds phase constant
// RQ4: output frequency is word times clock over 2^32
// RQ5: software keeps tuning word at most 2^31
// RQ6: both channels share one clock, lockstep
// RQ7: per-channel 14-bit offset added before cosine
// RQ8: phase shift is offset over 2^14 turns
// RQ9: amplitude samples are 10 bits wide
// RQ10: single-tone, two-level, sweep combine freely
// RQ11: both channels may run four-level modulation
// RQ12: eight/16-level on one channel, other single-tone
// RQ13: ramp on both channels in single-tone
// RQ14: two-pin ramp: one two-level or both sweeping
// RQ15: one-pin ramp: one eight-level, other single-tone
// RQ16: sdio ramp: two/four-level each, else single-tone
// RQ17: sdio ramp: one eight/16-level, other single-tone
// RQ18: amplitude modulation, sweep, ramp are exclusive
// RQ19: sync clock at quarter rate samples pins
// RQ20: update strobe rise copies buffers to active
// RQ21: pin config field selects profile pin function
// RQ22: offset aligned to top 14 phase bits
// RQ23: illegal mode combinations flagged, output undefined
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
`include "dds_defs.svh"

module dds_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] profile_pins,
    input wire logic io_update,
    output logic sync_clk,
    output logic [9:0] dac0_data,
    output logic [9:0] dac1_data
);
    import dds_pkg::*;

    logic [31:0] ctrl_r;
    logic [31:0] frq0_buf_r;
    logic [31:0] frq1_buf_r;
    logic [13:0] pho0_buf_r;
    logic [13:0] pho1_buf_r;
    logic [31:0] frq0_act_r;
    logic [31:0] frq1_act_r;
    logic [13:0] pho0_act_r;
    logic [13:0] pho1_act_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [1:0] div_r;
    logic sync_clk_r;
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic [3:0] pin_smp_r;
    logic upd_meta_r;
    logic upd_sync_r;
    logic upd_smp_r;
    logic upd_go;
    logic samp;
    logic legal_r;
    logic [31:0] acc0;
    logic [31:0] acc1;
    logic [9:0] dac0_r;
    logic [9:0] dac1_r;
    logic wr_go;
    logic setup;
    dds_mode_t m0;
    dds_mode_t m1;
    dds_mtype_t t0;
    dds_mtype_t t1;
    dds_rsrc_t rsrc;
    logic r0;
    logic r1;

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    function automatic logic is_hi(input dds_mode_t m);
        is_hi = (m == DDS_M8) || (m == DDS_M16);
    endfunction : is_hi

    function automatic logic is_mod(input dds_mode_t m);
        is_mod = (m == DDS_M2) || (m == DDS_M4) || is_hi(m);
    endfunction : is_mod

    // one channel's ramp is legal with the amplitude path free
    function automatic logic amp_ok(input dds_mode_t m, input dds_mtype_t t,
                                    input logic r);
        amp_ok = !(r && (m != DDS_ST) && (t == DDS_T_AMP)); // RQ18
    endfunction : amp_ok

    // role of the four profile pins for a pin config value
    // 0: modulation select, 1: sweep start/stop, 2: ramp control
    function automatic logic [1:0] pin_role(input logic [2:0] pcfg);
        case (pcfg)
            3'h0, 3'h1, 3'h2: pin_role = 2'h0;
            3'h3: pin_role = 2'h1;
            3'h4, 3'h5: pin_role = 2'h2;
            default: pin_role = 2'h0;
        endcase
    endfunction : pin_role

    // legality of the two-channel mode combination
    function automatic logic combo_ok(input dds_mode_t a, input dds_mode_t b,
                                      input dds_mtype_t ta, input dds_mtype_t tb,
                                      input logic ra, input logic rb,
                                      input dds_rsrc_t src);
        logic ok;
        ok = 1'b1;
        // eight/16-level keeps the other channel single-tone
        if (is_hi(a) && (b != DDS_ST)) begin
            ok = 1'b0; // RQ12
        end
        if (is_hi(b) && (a != DDS_ST)) begin
            ok = 1'b0; // RQ12
        end
        if (!amp_ok(a, ta, ra) || !amp_ok(b, tb, rb)) begin
            ok = 1'b0; // RQ18
        end
        if (ra || rb) begin
            case (src)
                DDS_RS_NONE: begin
                    ok = 1'b0;
                end
                DDS_RS_PIN23: begin
                    // both single-tone, one two-level, or both sweeping
                    if (!((a == DDS_ST && b == DDS_ST) // RQ13
                          || (a == DDS_M2 && b == DDS_ST) // RQ14
                          || (a == DDS_ST && b == DDS_M2)
                          || (a == DDS_SWP && b == DDS_SWP))) begin
                        ok = 1'b0;
                    end
                end
                DDS_RS_PIN3: begin
                    if (!((a == DDS_ST && b == DDS_ST)
                          || (a == DDS_M8 && b == DDS_ST) // RQ15
                          || (a == DDS_ST && b == DDS_M8))) begin
                        ok = 1'b0;
                    end
                end
                DDS_RS_SDIO: begin
                    // neither channel may sweep with the sdio ramp
                    if ((a == DDS_SWP) || (b == DDS_SWP)) begin
                        ok = 1'b0; // RQ16
                    end
                    // two- and four-level do not mix on these pins
                    if (is_mod(a) && is_mod(b) && (a != b)) begin
                        ok = 1'b0; // RQ16
                    end
                    if ((is_mod(a) && !ra) || (is_mod(b) && !rb)) begin
                        ok = 1'b0; // RQ16 RQ17
                    end
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
        end
        combo_ok = ok; // RQ10 RQ11
    endfunction : combo_ok

    assign m0 = dds_mode_t'(ctrl_r[`DDS_CTRL_M0_LSB +: 3]);
    assign m1 = dds_mode_t'(ctrl_r[`DDS_CTRL_M1_LSB +: 3]);
    assign t0 = dds_mtype_t'(ctrl_r[`DDS_CTRL_T0_LSB +: 2]);
    assign t1 = dds_mtype_t'(ctrl_r[`DDS_CTRL_T1_LSB +: 2]);
    assign rsrc = dds_rsrc_t'(ctrl_r[`DDS_CTRL_RSRC_LSB +: 2]);
    assign r0 = ctrl_r[`DDS_CTRL_R0_BIT];
    assign r1 = ctrl_r[`DDS_CTRL_R1_BIT];

    // ---------------------------------------------------------------
    // apb slave, zero wait states
    // ---------------------------------------------------------------
    assign setup = psel && !penable && !pready_r;
    assign wr_go = psel && penable && pready_r && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= 1'b0;
            case (paddr)
                `DDS_OFF_CTRL: prdata_r <= ctrl_r;
                `DDS_OFF_STATUS: prdata_r <= {22'h0, pin_role(ctrl_r[`DDS_CTRL_PCFG_LSB +: 3]),
                                              pin_smp_r, 3'h0, legal_r};
                `DDS_OFF_FRQ0: prdata_r <= frq0_buf_r;
                `DDS_OFF_FRQ1: prdata_r <= frq1_buf_r;
                `DDS_OFF_PHO0: prdata_r <= {18'h0, pho0_buf_r};
                `DDS_OFF_PHO1: prdata_r <= {18'h0, pho1_buf_r};
                `DDS_OFF_ACT0: prdata_r <= acc0;
                `DDS_OFF_ACT1: prdata_r <= acc1;
                default: begin
                    prdata_r <= 32'h0000_0000;
                    pslverr_r <= 1'b1;
                end
            endcase
        end else if (!psel) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end

    // control register, which acts at once, and buffers; only an update moves the buffers to the channels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `DDS_CTRL_RST;
            frq0_buf_r <= `DDS_FRQ_RST;
            frq1_buf_r <= `DDS_FRQ_RST;
            pho0_buf_r <= `DDS_PHO_RST;
            pho1_buf_r <= `DDS_PHO_RST;
        end else if (wr_go) begin
            case (paddr)
                `DDS_OFF_CTRL: ctrl_r <= pwdata & `DDS_CTRL_MASK; // RQ21
                `DDS_OFF_FRQ0: frq0_buf_r <= pwdata;
                `DDS_OFF_FRQ1: frq1_buf_r <= pwdata;
                `DDS_OFF_PHO0: pho0_buf_r <= pwdata[13:0];
                `DDS_OFF_PHO1: pho1_buf_r <= pwdata[13:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // sync clock and pin sampling
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 2'h0;
            sync_clk_r <= 1'b0;
        end else begin
            div_r <= div_r + 2'h1;
            sync_clk_r <= (div_r == `DDS_SYNC_SAMPLE) || (div_r == 2'h2); // RQ19
        end
    end

    // pins sampled as sync_clk rises
    assign samp = (div_r == `DDS_SYNC_SAMPLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
            upd_meta_r <= 1'b0;
            upd_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= profile_pins;
            pin_sync_r <= pin_meta_r;
            upd_meta_r <= io_update;
            upd_sync_r <= upd_meta_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_smp_r <= 4'h0;
            upd_smp_r <= 1'b0;
        end else if (samp) begin
            pin_smp_r <= pin_sync_r; // RQ19
            upd_smp_r <= upd_sync_r;
        end
    end

    // strobes shorter than one sync period may be missed
    assign upd_go = samp && upd_sync_r && !upd_smp_r; // RQ20

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frq0_act_r <= `DDS_FRQ_RST;
            frq1_act_r <= `DDS_FRQ_RST;
            pho0_act_r <= `DDS_PHO_RST;
            pho1_act_r <= `DDS_PHO_RST;
        end else if (upd_go) begin
            frq0_act_r <= frq0_buf_r; // RQ20
            frq1_act_r <= frq1_buf_r;
            pho0_act_r <= pho0_buf_r;
            pho1_act_r <= pho1_buf_r;
        end
    end

    // ---------------------------------------------------------------
    // mode checker; illegal combinations are only flagged
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            legal_r <= 1'b1;
        end else begin
            legal_r <= combo_ok(m0, m1, t0, t1, r0, r1, rsrc); // RQ23
        end
    end

    // ---------------------------------------------------------------
    // channels on the common clock
    // ---------------------------------------------------------------
    dds_chan u_ch0 (
        .pclk(pclk), // RQ6
        .presetn(presetn),
        .frequency_tuning_word(frq0_act_r),
        .channel_phase_offset(pho0_act_r),
        .acc_r(acc0),
        .dac_data_r(dac0_r)
    );

    dds_chan u_ch1 (
        .pclk(pclk), // RQ6
        .presetn(presetn),
        .frequency_tuning_word(frq1_act_r),
        .channel_phase_offset(pho1_act_r),
        .acc_r(acc1),
        .dac_data_r(dac1_r)
    );

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sync_clk = sync_clk_r;
    assign dac0_data = dac0_r;
    assign dac1_data = dac1_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_SYNC_QUARTER: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
        $rose(sync_clk_r) |-> ##1 sync_clk_r ##1 !sync_clk_r ##1 !sync_clk_r
        ##1 $rose(sync_clk_r))
        else $error("sync clock not at quarter rate");

    AST_UPDATE_COPY: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
        upd_go |=> (frq0_act_r == $past(frq0_buf_r))
        && (pho1_act_r == $past(pho1_buf_r)))
        else $error("update did not copy buffers");

    AST_ACTIVE_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
        !upd_go |=> $stable(frq0_act_r) && $stable(frq1_act_r))
        else $error("active word changed without update");

    AST_LOCKSTEP: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        (frq0_act_r == frq1_act_r) && (acc0 == acc1)
        && $stable(frq0_act_r) && $stable(frq1_act_r) |=> (acc0 == acc1))
        else $error("channels lost lockstep");

    AST_HI_EXCL: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        is_hi(m0) && (m1 != DDS_ST) |=> !legal_r)
        else $error("eight-level with busy partner accepted");

    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready_r ##1 !pready_r)
        else $error("apb ready not one access cycle");

endmodule : dds_core

// >>> common/dds_defs.svh
// register offsets, field positions and timing constants of the dds core
`ifndef DDS_DEFS_SVH
`define DDS_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define DDS_OFF_CTRL 8'h00
`define DDS_OFF_STATUS 8'h04
`define DDS_OFF_FRQ0 8'h08
`define DDS_OFF_FRQ1 8'h0C
`define DDS_OFF_PHO0 8'h10
`define DDS_OFF_PHO1 8'h14
`define DDS_OFF_ACT0 8'h18
`define DDS_OFF_ACT1 8'h1C

// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define DDS_CTRL_PCFG_LSB 0
`define DDS_CTRL_RSRC_LSB 4
`define DDS_CTRL_M0_LSB 8
`define DDS_CTRL_M1_LSB 12
`define DDS_CTRL_R0_BIT 16
`define DDS_CTRL_R1_BIT 17
`define DDS_CTRL_T0_LSB 18
`define DDS_CTRL_T1_LSB 20
`define DDS_CTRL_MASK 32'h003F_7737
`define DDS_CTRL_RST 32'h0000_0000

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define DDS_FRQ_RST 32'h0000_0000
`define DDS_PHO_RST 14'h0000
`define DDS_SYNC_DIV 4
`define DDS_SYNC_SAMPLE 2'h1
`define DDS_PHASE_QTR 14'h1000
`define DDS_DAC_MID 10'h200
`define DDS_HUMP_MAX 9'h1FF

`endif

// >>> common/dds_pkg.sv
// types shared by the dds core and its channel module
package dds_pkg;

    // ---------------------------------------------------------------
    // channel operating modes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        DDS_ST = 3'b000,
        DDS_M2 = 3'b001,
        DDS_M4 = 3'b010,
        DDS_M8 = 3'b011,
        DDS_M16 = 3'b100,
        DDS_SWP = 3'b101
    } dds_mode_t;

    // which pins carry amplitude ramp control
    typedef enum logic [1:0] {
        DDS_RS_NONE = 2'b00,
        DDS_RS_PIN23 = 2'b01,
        DDS_RS_PIN3 = 2'b10,
        DDS_RS_SDIO = 2'b11
    } dds_rsrc_t;

    // quantity that modulation or sweep acts on
    typedef enum logic [1:0] {
        DDS_T_FREQ = 2'b00,
        DDS_T_PHASE = 2'b01,
        DDS_T_AMP = 2'b10,
        DDS_T_RSV = 2'b11
    } dds_mtype_t;

endpackage : dds_pkg

// >>> logic/dds_chan.sv
// one synthesis channel: phase accumulator, phase offset, cosine amplitude
`timescale 1ns/10ps
`include "dds_defs.svh"

module dds_chan (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] frequency_tuning_word,
    input wire logic [13:0] channel_phase_offset,
    output logic [31:0] acc_r,
    output logic [9:0] dac_data_r
);
    import dds_pkg::*;

    logic [13:0] phase_r;
    logic [13:0] v;
    logic [12:0] w;
    logic [13:0] wc;
    logic [26:0] h;
    logic [8:0] mag;

    // ---------------------------------------------------------------
    // accumulator, wraps modulo 2^32
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= `DDS_FRQ_RST;
        end else begin
            acc_r <= acc_r + frequency_tuning_word; // RQ1 RQ3 RQ4
        end
    end

    // offset aligned to the top 14 phase bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= `DDS_PHO_RST;
        end else begin
            phase_r <= acc_r[31:18] + channel_phase_offset; // RQ7 RQ8 RQ22
        end
    end

    // ---------------------------------------------------------------
    // cosine as a shifted parabolic sine hump
    // ---------------------------------------------------------------
    // parabola trades a few lsb of purity for no lookup table
    assign v = phase_r + `DDS_PHASE_QTR; // RQ2
    assign w = v[12:0];
    assign wc = 14'h2000 - {1'b0, w};
    assign h = w * wc;
    assign mag = (h[24:15] > 10'h1FF) ? `DDS_HUMP_MAX : h[23:15];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_data_r <= `DDS_DAC_MID;
        end else if (v[13]) begin
            dac_data_r <= `DDS_DAC_MID - {1'b0, mag}; // RQ2 RQ9
        end else begin
            dac_data_r <= `DDS_DAC_MID + {1'b0, mag}; // RQ9
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_ACC_STEP: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        ##1 acc_r == $past(acc_r) + $past(frequency_tuning_word))
        else $error("accumulator did not step by tuning word");

    AST_ZERO_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        (frequency_tuning_word == 32'h0) ##1 (frequency_tuning_word == 32'h0)
        |-> $stable(acc_r))
        else $error("phase moved with zero tuning word");

    AST_OFFSET_ADD: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
        ##1 phase_r == $past(acc_r[31:18]) + $past(channel_phase_offset))
        else $error("phase offset not added to top phase bits");

    AST_COS_PEAK: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
        (phase_r == 14'h0000) |=> (dac_data_r == 10'h3FF))
        else $error("cosine peak wrong at phase zero");

    AST_COS_TROUGH: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        (phase_r == 14'h2000) |=> (dac_data_r == 10'h001))
        else $error("cosine trough wrong at half cycle");

endmodule : dds_chan

// >>> bench/dds_partner.sv
// far-side model: profile pin and update strobe driver, dac sample sink
`timescale 1ns/10ps

module dds_partner (
    input wire logic pclk,
    input wire logic [9:0] dac0_data,
    input wire logic [9:0] dac1_data,
    output logic [3:0] profile_pins,
    output logic io_update
);
    initial begin
        profile_pins = 4'h0;
        io_update = 1'b0;
    end

    // pins held long enough for sync, sample and status to settle
    task automatic set_pins(input logic [3:0] v);
        @(posedge pclk);
        profile_pins <= v;
        repeat (12) @(posedge pclk);
    endtask : set_pins

    // held two sync periods so the rise always meets a sample point
    task automatic pulse_update();
        @(posedge pclk);
        io_update <= 1'b1;
        repeat (8) @(posedge pclk);
        io_update <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : pulse_update
endmodule : dds_partner

// >>> bench/tb_dual_channel_dds_core.sv
// self-checking bench for the dual channel dds core
`timescale 1ns/10ps
`include "dds_defs.svh"

module tb_dual_channel_dds_core;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sync_clk;
    logic [3:0] profile_pins;
    logic io_update;
    logic [9:0] dac0_data;
    logic [9:0] dac1_data;
    int fail_count = 0;
    int samples_checked = 0;

    always #12.5 pclk = ~pclk;

    dds_core dds_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .profile_pins(profile_pins), .io_update(io_update),
        .sync_clk(sync_clk), .dac0_data(dac0_data), .dac1_data(dac1_data));

    dds_partner dds_partner_inst (.pclk(pclk), .dac0_data(dac0_data), .dac1_data(dac1_data),
        .profile_pins(profile_pins), .io_update(io_update));

    task automatic tally_and_finish();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // ---------------------------------------------------------------
    // apb master
    // ---------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED %0t no pready", $time);
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask : rd

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_vals();
        logic [31:0] r;
        rd(`DDS_OFF_CTRL, r);
        chk(r, `DDS_CTRL_RST, "ctrl reset");
        rd(`DDS_OFF_FRQ1, r);
        chk(r, `DDS_FRQ_RST, "tuning word reset");
        rd(`DDS_OFF_STATUS, r);
        chk({31'h0000_0000, r[0]}, 32'h0000_0001, "legal at reset");
        chk({22'h00_0000, dac0_data}, 32'h0000_03FF, "dac0 phase zero");
        chk({22'h00_0000, dac1_data}, 32'h0000_03FF, "dac1 phase zero");
    endtask : t_reset_vals

    task automatic t_sync();
        logic [3:0] pat;
        int n = 0;
        // settle first so a rise at this very edge is not half seen
        #1;
        while (sync_clk !== 1'b0 && n < 8) begin
            @(posedge pclk);
            #1 n++;
        end
        while (sync_clk !== 1'b1 && n < 16) begin
            @(posedge pclk);
            #1 n++;
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            #1 pat[3 - i] = sync_clk;
        end
        chk({28'h000_0000, pat}, 32'h0000_0009, "sync clock shape");
    endtask : t_sync

    task automatic t_unmapped();
        logic [31:0] r;
        logic e;
        apb(1'b1, 8'h20, 32'hFFFF_FFFF, r, e);
        chk({31'h0000_0000, e}, 32'h0000_0001, "unmapped write err");
        apb(1'b0, 8'h24, 32'h0000_0000, r, e);
        chk({r[30:0], e}, 32'h0000_0001, "unmapped read");
        wr(`DDS_OFF_STATUS, 32'h0000_0000);
        rd(`DDS_OFF_STATUS, r);
        chk({31'h0000_0000, r[0]}, 32'h0000_0001, "status read only");
    endtask : t_unmapped

    task automatic t_modes();
        logic [31:0] r;
        logic [31:0] cv [14] = '{32'h0000_5100, 32'h0000_2200, 32'h0000_2300, 32'h0000_4000,
            32'h0003_0010, 32'h0003_5510, 32'h0001_0320, 32'h0001_1320, 32'h0003_2230,
            32'h0003_1430, 32'h0009_0110, 32'h0001_0110, 32'h0003_1230, 32'h0001_0430};
        logic le [14] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
            1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 14; i++) begin
            wr(`DDS_OFF_CTRL, cv[i]);
            rd(`DDS_OFF_STATUS, r);
            chk(r & 32'h1, 32'(le[i]), "legal");
        end
        wr(`DDS_OFF_CTRL, 32'hFFFF_FFFF);
        rd(`DDS_OFF_CTRL, r);
        chk(r, `DDS_CTRL_MASK, "ctrl mask");
    endtask : t_modes

    task automatic t_pins();
        logic [31:0] r;
        logic [2:0] pcfg [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
        logic [1:0] role [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        for (int i = 0; i < 4; i++) begin
            wr(`DDS_OFF_CTRL, {29'h0000_0000, pcfg[i]});
            dds_partner_inst.set_pins(4'hA ^ i[3:0]);
            rd(`DDS_OFF_STATUS, r);
            chk({26'h000_0000, r[9:4]}, {26'h000_0000, role[i], 4'hA ^ i[3:0]}, "pins");
        end
    endtask : t_pins

    task automatic t_accum();
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        wr(`DDS_OFF_FRQ0, 32'h0000_0100);
        wr(`DDS_OFF_FRQ1, 32'h0000_0200);
        rd(`DDS_OFF_ACT0, a);
        chk(a, 32'h0000_0000, "no update no step");
        dds_partner_inst.pulse_update();
        rd(`DDS_OFF_ACT0, a);
        rd(`DDS_OFF_ACT1, b);
        rd(`DDS_OFF_ACT0, c);
        chk(c - a, 32'h0000_0600, "acc step");
        chk(b, (a + 32'h0000_0300) << 1, "lockstep");
        wr(`DDS_OFF_FRQ0, 32'h8000_0000);
        dds_partner_inst.pulse_update();
        rd(`DDS_OFF_ACT0, a);
        rd(`DDS_OFF_ACT0, c);
        chk(c - a, 32'h8000_0000, "acc wrap");
    endtask : t_accum

    task automatic t_phase();
        logic [31:0] a;
        logic [31:0] c;
        logic [13:0] p;
        logic [9:0] x;
        wr(`DDS_OFF_FRQ0, 32'h0000_0000);
        wr(`DDS_OFF_FRQ1, 32'h0000_0000);
        dds_partner_inst.pulse_update();
        rd(`DDS_OFF_ACT0, a);
        rd(`DDS_OFF_ACT0, c);
        chk(c, a, "zero word holds");
        p = 14'h0000 - a[31:18];
        wr(`DDS_OFF_PHO0, {18'h0_0000, p});
        dds_partner_inst.pulse_update();
        chk({22'h00_0000, dac0_data}, 32'h0000_03FF, "offset cancels");
        wr(`DDS_OFF_PHO0, {18'h0_0000, p + 14'h2000});
        dds_partner_inst.pulse_update();
        chk({22'h00_0000, dac0_data}, 32'h0000_0001, "half turn");
        x = dac0_data;
        repeat (8) @(posedge pclk);
        chk({22'h00_0000, dac0_data}, {22'h00_0000, x}, "dac held");
    endtask : t_phase

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_sync();
        t_unmapped();
        t_modes();
        t_pins();
        t_accum();
        t_phase();
        tally_and_finish();
    end
endmodule : tb_dual_channel_dds_core
